// [hdl/scd_pkg.sv]
// constants for the step-down converter control register bank
// assumes an 8-bit register port driven by the control-bus slave
package scd_pkg;
    // register offsets
    localparam logic [7:0] IO_MISC_OFS    = 8'haa;
    localparam logic [7:0] IO_OSC_OFS     = 8'had;
    localparam logic [7:0] IO_VSEL_OFS    = 8'haf;
    localparam logic [7:0] C1_GROUP_OFS   = 8'hb0;
    localparam logic [7:0] C1_KIND_OFS    = 8'hb1;
    localparam logic [7:0] C1_REMAP_OFS   = 8'hb2;
    localparam logic [7:0] C1_CFG_OFS     = 8'hb3;
    localparam logic [7:0] C1_MISC_OFS    = 8'hb4;
    localparam logic [7:0] C1_OSC_OFS     = 8'hb7;
    localparam logic [7:0] C1_VSEL_OFS    = 8'hb9;
    localparam logic [7:0] C1_MODE_OFS    = 8'hba;
    localparam logic [7:0] C1_FLOOR_OFS   = 8'hbb;
    // io converter config register sits just below misc config
    localparam logic [7:0] IO_CFG_OFS     = 8'ha9;
    // field positions
    localparam int CFG_PWM_BIT    = 1;
    localparam int CFG_HIZ_BIT    = 0;
    localparam int GRP_WARM_BIT   = 4;
    localparam int MODE_BUSY_BIT  = 5;
    localparam int MODE_FLOOR_BIT = 3;
    localparam int MODE_SLP_BIT   = 2;
    localparam int MODE_RDSRC_BIT = 1;
    localparam int MODE_RSV_BIT   = 0;
    localparam int OSC_RSV_BIT    = 6;
    // reset values
    localparam logic [2:0] C1_GROUP_RST = 3'h1;
    localparam logic [2:0] GROUP_ALL    = 3'h7;
    localparam logic [2:0] C1_KIND_RST  = 3'h4;
    localparam logic [3:0] OFF_MAP_RST  = 4'h0;
    localparam logic [3:0] SLP_MAP_RST  = 4'h8;
    localparam logic [6:0] C1_VSEL_RST  = 7'h30;
    localparam logic [6:0] FLOOR_RST    = 7'h00;
    localparam logic       IO_VSEL_RST  = 1'b0;
    // scramble keys: register code = level ^ key
    localparam logic [2:0] IO_DRIVE_KEY = 3'h5;
    localparam logic [2:0] C1_DRIVE_KEY = 3'h3;
    localparam logic [2:0] OVLAP_KEY    = 3'h6;
    // voltage step timing
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int STEP_TIME_NS   = 10000;
    localparam int STEP_CYCLES    = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;
endpackage

// [hdl/scd_vtrack.sv]
// core converter output code tracker: steps toward the target code
// assumes target and floor codes are synchronous to mclk
module scd_vtrack #(
    parameter int STEP_CYCLES = scd_pkg::STEP_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [6:0] target,
    input  wire logic [6:0] floor_code,
    input  wire logic       use_floor,
    output logic      [6:0] cur_code,
    output logic            busy,
    output logic            floor_hit
);
    localparam int CW = $clog2(STEP_CYCLES + 1);

    if (STEP_CYCLES < 1) begin : g_chk
        $error("STEP_CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt;
    wire           step_now = (cnt == '0) && (cur_code != target);
    wire [6:0]     step_to  = (cur_code < target) ? cur_code + 7'h01 : cur_code - 7'h01;
    wire [6:0]     next_cur = step_now ? step_to : cur_code;
    wire [CW-1:0]  next_cnt = step_now ? CW'(STEP_CYCLES - 1) : ((cnt != '0) ? cnt - 1'b1 : cnt);

    ////////////////////////////////////////////////////////////////
    // ramp output code
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cur_code <= scd_pkg::C1_VSEL_RST;
            cnt      <= '0;
        end else begin
            cur_code <= next_cur;
            cnt      <= next_cnt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy      <= 1'b0;
            floor_hit <= 1'b0;
        end else begin
            busy      <= (next_cur != target);
            floor_hit <= use_floor && (next_cur == floor_code);
        end
    end

    ////////////////////////////////////////////////////////////////
    chk_busy_settled: assert property (@(posedge mclk) disable iff (!nrst)
        !busy && $stable(target) |-> cur_code == target)
        else $error("busy clear while output differs from target");

    chk_floor_hit: assert property (@(posedge mclk) disable iff (!nrst)
        floor_hit && $stable(floor_code) |-> cur_code == floor_code)
        else $error("floor flag set away from floor code");

    sequence s_moved;
        $changed(cur_code);
    endsequence
    chk_step_rate: assert property (@(posedge mclk) disable iff (!nrst)
        (STEP_CYCLES > 1) and s_moved |=> $stable(cur_code))
        else $error("output code stepped faster than step period");
endmodule

// [hdl/scd_regs.sv]
// step-down converter control registers: io converter and core one converter
// assumes a byte register port from the control-bus slave, all inputs on mclk
module scd_regs #(
    parameter int STEP_CYCLES = scd_pkg::STEP_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       warm_reset,
    input  wire logic [3:0] core_state,
    input  wire logic       sleep_req,
    input  wire logic       avs_enable,
    input  wire logic [6:0] avs_code,
    output logic            io_force_pwm_sync_switch,
    output logic            io_high_impedance_disable_mode,
    output logic      [1:0] io_analog_test_mux_select,
    output logic      [2:0] io_drive_level,
    output logic      [2:0] io_overlap_level,
    output logic      [1:0] io_ramp_switch_tune,
    output logic            io_output_select,
    output logic      [2:0] core_group_membership,
    output logic      [2:0] core_resource_kind,
    output logic      [1:0] core_secondary_resource_kind,
    output logic      [3:0] core_off_remap,
    output logic      [3:0] core_sleep_remap,
    output logic            core_force_pwm_sync_switch,
    output logic            core_high_impedance_disable_mode,
    output logic      [1:0] core_analog_test_mux_select,
    output logic      [2:0] core_drive_level,
    output logic      [2:0] core_overlap_level,
    output logic      [1:0] core_ramp_switch_tune,
    output logic      [6:0] core_vout_code,
    output logic            core_transition_busy_flag,
    output logic            core_floor_reached_flag
);
    ////////////////////////////////////////////////////////////////
    // write decode
    wire wr_io_cfg  = reg_wr && (reg_addr == scd_pkg::IO_CFG_OFS);
    wire wr_io_misc = reg_wr && (reg_addr == scd_pkg::IO_MISC_OFS);
    wire wr_io_osc  = reg_wr && (reg_addr == scd_pkg::IO_OSC_OFS);
    wire wr_io_vsel = reg_wr && (reg_addr == scd_pkg::IO_VSEL_OFS);
    wire wr_grp     = reg_wr && (reg_addr == scd_pkg::C1_GROUP_OFS);
    wire wr_kind    = reg_wr && (reg_addr == scd_pkg::C1_KIND_OFS);
    wire wr_remap   = reg_wr && (reg_addr == scd_pkg::C1_REMAP_OFS);
    wire wr_c_cfg   = reg_wr && (reg_addr == scd_pkg::C1_CFG_OFS);
    wire wr_c_misc  = reg_wr && (reg_addr == scd_pkg::C1_MISC_OFS);
    wire wr_c_osc   = reg_wr && (reg_addr == scd_pkg::C1_OSC_OFS);
    wire wr_vsel    = reg_wr && (reg_addr == scd_pkg::C1_VSEL_OFS);
    wire wr_mode    = reg_wr && (reg_addr == scd_pkg::C1_MODE_OFS);
    wire wr_floor   = reg_wr && (reg_addr == scd_pkg::C1_FLOOR_OFS);

    logic       io_osc_rsv;
    logic       core_osc_rsv;
    logic       core_warm_cfg;
    logic [3:0] core_state_q;
    logic [6:0] core_vsel;
    logic       mode_rsv;
    logic       read_src;
    logic       sleep_floor_enable;
    logic [6:0] sleep_floor_voltage;

    ////////////////////////////////////////////////////////////////
    // io converter config
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_force_pwm_sync_switch       <= 1'b0;
            io_high_impedance_disable_mode <= 1'b0;
        end else if (wr_io_cfg) begin
            io_force_pwm_sync_switch       <= reg_wdata[scd_pkg::CFG_PWM_BIT];
            io_high_impedance_disable_mode <= reg_wdata[scd_pkg::CFG_HIZ_BIT];
        end
    end

    // io drive stored as unscrambled level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_analog_test_mux_select <= 2'h0;
            io_drive_level            <= scd_pkg::IO_DRIVE_KEY;
        end else if (wr_io_misc) begin
            io_analog_test_mux_select <= reg_wdata[4:3];
            io_drive_level            <= reg_wdata[2:0] ^ scd_pkg::IO_DRIVE_KEY;
        end
    end

    // io overlap stored as unscrambled level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_osc_rsv          <= 1'b0;
            io_overlap_level    <= scd_pkg::OVLAP_KEY;
            io_ramp_switch_tune <= 2'h0;
        end else if (wr_io_osc) begin
            io_osc_rsv          <= reg_wdata[scd_pkg::OSC_RSV_BIT];
            io_overlap_level    <= reg_wdata[4:2] ^ scd_pkg::OVLAP_KEY;
            io_ramp_switch_tune <= reg_wdata[1:0];
        end
    end

    // io output select, default on warm reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_output_select <= scd_pkg::IO_VSEL_RST;
        end else if (warm_reset) begin
            io_output_select <= scd_pkg::IO_VSEL_RST;
        end else if (wr_io_vsel) begin
            io_output_select <= reg_wdata[0];
        end
    end

    // group mask, warm reset forces all groups when the stored warm bit is set
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_group_membership <= scd_pkg::C1_GROUP_RST;
            core_warm_cfg         <= 1'b0;
        end else begin
            if (warm_reset && core_warm_cfg) begin
                core_group_membership <= scd_pkg::GROUP_ALL;
            end else if (wr_grp) begin
                core_group_membership <= reg_wdata[7:5];
            end
            if (wr_grp) begin
                core_warm_cfg <= reg_wdata[scd_pkg::GRP_WARM_BIT];
            end
        end
    end

    // power state follows its source, never written
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_state_q <= 4'h0;
        end else begin
            core_state_q <= core_state;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_resource_kind           <= scd_pkg::C1_KIND_RST;
            core_secondary_resource_kind <= 2'h0;
        end else if (wr_kind) begin
            core_resource_kind           <= reg_wdata[2:0];
            core_secondary_resource_kind <= reg_wdata[4:3];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_off_remap   <= scd_pkg::OFF_MAP_RST;
            core_sleep_remap <= scd_pkg::SLP_MAP_RST;
        end else if (wr_remap) begin
            core_off_remap   <= reg_wdata[7:4];
            core_sleep_remap <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_force_pwm_sync_switch       <= 1'b0;
            core_high_impedance_disable_mode <= 1'b0;
        end else if (wr_c_cfg) begin
            core_force_pwm_sync_switch       <= reg_wdata[scd_pkg::CFG_PWM_BIT];
            core_high_impedance_disable_mode <= reg_wdata[scd_pkg::CFG_HIZ_BIT];
        end
    end

    // core drive level and test mux
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_analog_test_mux_select <= 2'h0;
            core_drive_level            <= scd_pkg::C1_DRIVE_KEY;
        end else if (wr_c_misc) begin
            core_analog_test_mux_select <= reg_wdata[4:3];
            core_drive_level            <= reg_wdata[2:0] ^ scd_pkg::C1_DRIVE_KEY;
        end
    end

    // core overlap and stored reserved bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_osc_rsv          <= 1'b0;
            core_overlap_level    <= scd_pkg::OVLAP_KEY;
            core_ramp_switch_tune <= 2'h0;
        end else if (wr_c_osc) begin
            core_osc_rsv          <= reg_wdata[scd_pkg::OSC_RSV_BIT];
            core_overlap_level    <= reg_wdata[4:2] ^ scd_pkg::OVLAP_KEY;
            core_ramp_switch_tune <= reg_wdata[1:0];
        end
    end

    // stored output select, default on warm reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_vsel <= scd_pkg::C1_VSEL_RST;
        end else if (warm_reset) begin
            core_vsel <= scd_pkg::C1_VSEL_RST;
        end else if (wr_vsel) begin
            core_vsel <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_rsv           <= 1'b0;
            read_src           <= 1'b0;
            sleep_floor_enable <= 1'b0;
        end else if (wr_mode) begin
            mode_rsv           <= reg_wdata[scd_pkg::MODE_RSV_BIT];
            read_src           <= reg_wdata[scd_pkg::MODE_RDSRC_BIT];
            sleep_floor_enable <= reg_wdata[scd_pkg::MODE_SLP_BIT];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sleep_floor_voltage <= scd_pkg::FLOOR_RST;
        end else if (wr_floor) begin
            sleep_floor_voltage <= reg_wdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // target selection
    wire       use_floor   = sleep_req && sleep_floor_enable;
    wire [6:0] active_code = avs_enable ? avs_code : core_vsel;
    wire [6:0] trk_target  = use_floor ? sleep_floor_voltage : active_code;

    scd_vtrack #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_vtrack (
        .mclk      (mclk),
        .nrst      (nrst),
        .target    (trk_target),
        .floor_code(sleep_floor_voltage),
        .use_floor (use_floor),
        .cur_code  (core_vout_code),
        .busy      (core_transition_busy_flag),
        .floor_hit (core_floor_reached_flag)
    );

    ////////////////////////////////////////////////////////////////
    // output select read source
    wire [6:0] vsel_view = read_src ? core_vsel : core_vout_code;
    wire [7:0] mode_view = {2'h0, core_transition_busy_flag, 1'b0, core_floor_reached_flag,
                            sleep_floor_enable, read_src, mode_rsv};
    logic [7:0] next_rdata;

    always_comb begin
        case (reg_addr)
            scd_pkg::IO_CFG_OFS:   next_rdata = {6'h00, io_force_pwm_sync_switch,
                                                 io_high_impedance_disable_mode};
            scd_pkg::IO_MISC_OFS:  next_rdata = {3'h0, io_analog_test_mux_select,
                                                 io_drive_level ^ scd_pkg::IO_DRIVE_KEY};
            scd_pkg::IO_OSC_OFS:   next_rdata = {1'b0, io_osc_rsv, 1'b0,
                                                 io_overlap_level ^ scd_pkg::OVLAP_KEY, io_ramp_switch_tune};
            scd_pkg::IO_VSEL_OFS:  next_rdata = {7'h00, io_output_select};
            scd_pkg::C1_GROUP_OFS: next_rdata = {core_group_membership, core_warm_cfg, core_state_q};
            scd_pkg::C1_KIND_OFS:  next_rdata = {3'h0, core_secondary_resource_kind, core_resource_kind};
            scd_pkg::C1_REMAP_OFS: next_rdata = {core_off_remap, core_sleep_remap};
            scd_pkg::C1_CFG_OFS:   next_rdata = {6'h00, core_force_pwm_sync_switch,
                                                 core_high_impedance_disable_mode};
            scd_pkg::C1_MISC_OFS:  next_rdata = {3'h0, core_analog_test_mux_select,
                                                 core_drive_level ^ scd_pkg::C1_DRIVE_KEY};
            scd_pkg::C1_OSC_OFS:   next_rdata = {1'b0, core_osc_rsv, 1'b0,
                                                 core_overlap_level ^ scd_pkg::OVLAP_KEY, core_ramp_switch_tune};
            scd_pkg::C1_VSEL_OFS:  next_rdata = {1'b0, vsel_view};
            scd_pkg::C1_MODE_OFS:  next_rdata = mode_view;
            scd_pkg::C1_FLOOR_OFS: next_rdata = {1'b0, sleep_floor_voltage};
            default:               next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    chk_cfg_bits: assert property (@(posedge mclk) disable iff (!nrst)
        wr_c_cfg |=> core_force_pwm_sync_switch == $past(reg_wdata[1])
                     && core_high_impedance_disable_mode == $past(reg_wdata[0]))
        else $error("core config bits not taken from write");

    chk_io_drive: assert property (@(posedge mclk) disable iff (!nrst)
        wr_io_misc |=> io_drive_level == ($past(reg_wdata[2:0]) ^ 3'h5))
        else $error("io drive level not descrambled");

    chk_core_drive: assert property (@(posedge mclk) disable iff (!nrst)
        wr_c_misc |=> core_drive_level == ($past(reg_wdata[2:0]) ^ 3'h3))
        else $error("core drive level not descrambled");

    chk_overlap_map: assert property (@(posedge mclk) disable iff (!nrst)
        wr_c_osc |=> core_overlap_level == ($past(reg_wdata[4:2]) ^ 3'h6))
        else $error("overlap level not descrambled");

    chk_io_vsel_read: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd && reg_addr == scd_pkg::IO_VSEL_OFS |=> reg_rdata[7:1] == 7'h00
                                                     && reg_rdata[0] == $past(io_output_select))
        else $error("io output select read wrong");

    sequence s_warm_all;
        warm_reset && core_warm_cfg;
    endsequence
    chk_warm_group: assert property (@(posedge mclk) disable iff (!nrst)
        s_warm_all |=> core_group_membership == 3'h7 && io_output_select == 1'b0)
        else $error("warm reset did not force group and output select");

    chk_state_read: assert property (@(posedge mclk) disable iff (!nrst)
        reg_rd && reg_addr == scd_pkg::C1_GROUP_OFS |=> reg_rdata[3:0] == $past(core_state_q))
        else $error("state bits do not report power state");

    sequence s_live_read;
        reg_rd && reg_addr == scd_pkg::C1_VSEL_OFS && !read_src;
    endsequence
    chk_vsel_live: assert property (@(posedge mclk) disable iff (!nrst)
        s_live_read |=> reg_rdata == {1'b0, $past(core_vout_code)})
        else $error("output select read did not return live code");

    chk_sleep_floor: assert property (@(posedge mclk) disable iff (!nrst)
        use_floor && $stable({use_floor, sleep_floor_voltage}) && !core_transition_busy_flag
            |-> core_vout_code == sleep_floor_voltage)
        else $error("sleep output is not at the floor voltage");
endmodule

// [testbench/scd_host.sv]
// host model: single byte accesses on the register port
// assumes strobes are taken on rising mclk; drives at the falling edge
module scd_host (
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge mclk);
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge mclk);
        {reg_rd, reg_addr} = {1'b0, ~a};
        d = reg_rdata;
    endtask
endmodule

// [testbench/test_scd_regs.sv]
// testbench for the converter register bank
// assumes the host model above and a shortened step time
module test_scd_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, nrst, reg_wr, reg_rd, warm_reset, sleep_req, avs_enable, io_force_pwm_sync_switch,
        io_high_impedance_disable_mode, io_output_select, core_force_pwm_sync_switch,
        core_high_impedance_disable_mode, core_transition_busy_flag, core_floor_reached_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [6:0] avs_code, core_vout_code;
    logic [3:0] core_state, core_off_remap, core_sleep_remap;
    logic [2:0] io_drive_level, io_overlap_level, core_group_membership, core_resource_kind, core_drive_level,
        core_overlap_level;
    logic [1:0] io_analog_test_mux_select, io_ramp_switch_tune, core_secondary_resource_kind,
        core_analog_test_mux_select, core_ramp_switch_tune;
    int err_count = 0, n_tests = 0, n;
    logic [7:0] ra [14] = '{8'ha9, 8'haa, 8'had, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb7, 8'hba, 8'hbb,
        8'hc0, 8'ha8};
    logic [7:0] rv [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h04, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic [7:0] rw [14] = '{8'h03, 8'h1f, 8'h5f, 8'h01, 8'hf0, 8'h1f, 8'hff, 8'h03, 8'h1f, 8'h5f, 8'h07,
        8'h7f, 8'h00, 8'h00};
    logic [2:0] io_tab [8] = '{3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h0, 3'h3, 3'h2};
    logic [2:0] c1_tab [8] = '{3'h3, 3'h2, 3'h1, 3'h0, 3'h7, 3'h6, 3'h5, 3'h4};
    logic [2:0] ov_tab [8] = '{3'h6, 3'h7, 3'h4, 3'h5, 3'h2, 3'h3, 3'h0, 3'h1};
    scd_host h (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    scd_regs #(.STEP_CYCLES(3)) uut (.mclk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .warm_reset, .core_state, .sleep_req, .avs_enable, .avs_code, .io_force_pwm_sync_switch,
        .io_high_impedance_disable_mode, .io_analog_test_mux_select, .io_drive_level, .io_overlap_level,
        .io_ramp_switch_tune, .io_output_select, .core_group_membership, .core_resource_kind,
        .core_secondary_resource_kind, .core_off_remap, .core_sleep_remap, .core_force_pwm_sync_switch,
        .core_high_impedance_disable_mode, .core_analog_test_mux_select, .core_drive_level,
        .core_overlap_level, .core_ramp_switch_tune, .core_vout_code, .core_transition_busy_flag,
        .core_floor_reached_flag);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
    endtask
    task automatic pulse_warm();
        @(negedge mclk) warm_reset = 1'b1;
        @(negedge mclk) warm_reset = 1'b0;
    endtask
    task automatic wait_code(input logic [6:0] v);
        n = 0;
        while (core_vout_code !== v && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk("vout code", {1'b0, core_vout_code}, {1'b0, v});
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 14; i++) begin
            h.rd(ra[i], d);
            chk("reset value", d, rv[i]);
        end
        h.rd(8'hb9, d);
        chk("vsel reset", d, 8'h30);
        chk("reset levels", {1'b0, io_drive_level, 1'b0, core_drive_level}, 8'h53);
        for (int i = 0; i < 14; i++) h.wr(ra[i], 8'hff);
        for (int i = 0; i < 14; i++) begin
            h.rd(ra[i], d);
            chk("written value", d, rw[i]);
        end
        chk("cfg outputs", {io_force_pwm_sync_switch, io_high_impedance_disable_mode, core_force_pwm_sync_switch,
            core_high_impedance_disable_mode, io_analog_test_mux_select, core_analog_test_mux_select}, 8'hff);
        chk("remap outputs", {core_off_remap, core_sleep_remap}, 8'hff);
        chk("kind outputs", {3'h0, core_secondary_resource_kind, core_resource_kind}, 8'h1f);
        chk("ramp outputs", {4'h0, io_ramp_switch_tune, core_ramp_switch_tune}, 8'h0f);
        $display("register test done");
    endtask
    task automatic t_scramble();
        for (int l = 0; l < 8; l++) begin
            h.wr(8'haa, {5'h00, io_tab[l]});
            h.wr(8'hb4, {5'h00, c1_tab[l]});
            h.wr(8'had, {3'h0, ov_tab[l], 2'h0});
            h.wr(8'hb7, {3'h0, ov_tab[l], 2'h0});
            chk("drive levels", {1'b0, io_drive_level, 1'b0, core_drive_level}, {1'b0, l[2:0], 1'b0, l[2:0]});
            chk("overlap levels", {1'b0, io_overlap_level, 1'b0, core_overlap_level}, {1'b0, l[2:0], 1'b0, l[2:0]});
        end
        $display("scramble test done");
    endtask
    task automatic t_warm();
        core_state = 4'h9;
        h.wr(8'hb0, 8'h1f);
        h.wr(8'haf, 8'h01);
        h.wr(8'hb9, 8'h35);
        h.rd(8'hb0, d);
        chk("state report", d, 8'h19);
        chk("io vsel set", {7'h00, io_output_select}, 8'h01);
        pulse_warm();
        h.wr(8'hba, 8'h02);
        h.rd(8'hb9, d);
        chk("vsel after warm", d, 8'h30);
        chk("io vsel after warm", {7'h00, io_output_select}, 8'h00);
        chk("group after warm", {5'h00, core_group_membership}, 8'h07);
        h.wr(8'hb0, 8'h40);
        pulse_warm();
        chk("group kept", {5'h00, core_group_membership}, 8'h02);
        $display("warm reset test done");
    endtask
    task automatic t_vtrack();
        do_reset();
        h.wr(8'hb9, 8'h32);
        wait_code(7'h31);
        chk("busy stepping", {7'h00, core_transition_busy_flag}, 8'h01);
        wait_code(7'h32);
        chk("step spacing", {7'h00, n >= 3}, 8'h01);
        chk("busy idle", {7'h00, core_transition_busy_flag}, 8'h00);
        {avs_code, avs_enable} = {7'h2a, 1'b1};
        wait_code(7'h2a);
        h.rd(8'hb9, d);
        chk("live read", d, 8'h2a);
        h.wr(8'hba, 8'h02);
        h.rd(8'hb9, d);
        chk("stored read", d, 8'h32);
        avs_enable = 1'b0;
        h.wr(8'hbb, 8'h2e);
        h.wr(8'hba, 8'h04);
        sleep_req = 1'b1;
        wait_code(7'h2e);
        repeat (2) @(negedge mclk);
        h.rd(8'hba, d);
        chk("floor status", d, 8'h0c);
        $display("voltage tracking test done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #50000;
        err_count++;
        end_of_test();
    end
    initial begin
        {nrst, warm_reset, sleep_req, avs_enable, avs_code, core_state} = '0;
        do_reset();
        t_regs();
        t_scramble();
        t_warm();
        t_vtrack();
        end_of_test();
    end
endmodule
